// >>> hw/gdo_cfg_if.sv
`timescale 1ns/1ps
// read and write port between the top and the register store
interface gdo_cfg_if;
   logic [1:0] idx;   // register index
   logic       we;    // write strobe
   logic [7:0] wdata; // write data
   logic [7:0] rdata; // registered read data
   modport host (output idx, output we, output wdata, input rdata);
   modport store (input idx, input we, input wdata, output rdata);
endinterface : gdo_cfg_if

// >>> hw/gdo_cfg_top.sv
`timescale 1ns/1ps
`include "gdo_map.svh"
// pin configuration and fifo threshold bank
module gdo_cfg_top (
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             RST,
   // register access from the serial interface
   input  wire gdo_pkg::gdo_addr_t ADDR,
   input  wire logic             WE,
   input  wire logic             RE,
   input  wire gdo_pkg::gdo_byte_t WDATA,
   output gdo_pkg::gdo_byte_t    RDATA,
   output logic                  RVALID,
   // raw signals from the core, selected per pin
   input  wire logic [63:0]      PIN_SIGNALS,
   // sleep wake event
   input  wire logic             WAKE,
   // fifo byte counts
   input  wire gdo_pkg::gdo_count_t TX_COUNT,
   input  wire gdo_pkg::gdo_count_t RX_COUNT,
   // pin outputs
   output logic [2:0]            PIN_OUT,
   output logic [2:0]            PIN_OE,
   output logic                  DRIVE_HIGH,
   output logic                  TEMP_SENSOR_EN,
   // analog side and fifo threshold flags
   output gdo_pkg::gdo_byte_t    ANALOG_TEST_A,
   output gdo_pkg::gdo_byte_t    ANALOG_TEST_B,
   output logic [1:0]            RX_ATTEN,
   output logic                  TX_THR_HIT,
   output logic                  RX_THR_HIT
);
   import gdo_pkg::*;

   //------------------------------------------------------------
   // register store
   //------------------------------------------------------------
   gdo_cfg_if   cfg ();          // store access
   logic [31:0] regs;            // live register contents
   logic        hit;             // address in bank
   logic        rd_pend_r, rd_pend_nxt;   // mapped read in flight
   logic [7:0]  rdata_nxt;               // next read answer byte

   // decode: only offsets 0..3 belong here, others ignored
   always_comb begin
      hit       = (ADDR <= `GDO_OFS_FIFOTH);
      cfg.idx   = ADDR[1:0];
      cfg.we    = WE & hit;
      cfg.wdata = WDATA;
   end

   gdo_reg_store u_store (
      .CLK    (CLK),
      .RST    (RST),
      .bus    (cfg.store),
      .regs_q (regs)
   );

   // read answer one cycle after store data registers; unmapped reads 0
   always_comb begin
      rd_pend_nxt = RE & hit;
      rdata_nxt   = rd_pend_r ? cfg.rdata : 8'h00;
   end

   //------------------------------------------------------------
   // field views
   //------------------------------------------------------------
   logic [7:0] pin2_output_config, pin1_output_config;
   logic [7:0] pin0_output_config, fifo_threshold_config;
   assign pin2_output_config    = regs[7:0];
   assign pin1_output_config    = regs[15:8];
   assign pin0_output_config    = regs[23:16];
   assign fifo_threshold_config = regs[31:24];

   //------------------------------------------------------------
   // crystal divide-by-192 square-wave clock
   //------------------------------------------------------------
   logic [7:0] div_r, div_nxt;   // divider count
   logic       clkdiv_r, clkdiv_nxt;
   always_comb begin
      div_nxt    = div_r + 8'h01;
      clkdiv_nxt = clkdiv_r;
      if (div_r == 8'((`GDO_DIV_COUNT / 2) - 1)) begin
         div_nxt    = 8'h00;
         clkdiv_nxt = ~clkdiv_r;   // full period is 192 cycles
      end
   end

   // pick one signal for a pin; chip-ready goes through the same inversion as any other
   function automatic logic [1:0] gdo_pick(input logic [7:0] cfgb, input logic [63:0] sig, input logic cd);
      logic [5:0] sel;
      logic       v;
      sel = cfgb[`GDO_SEL_HI:0];
      v   = (sel == `GDO_SEL_CLKDIV) ? cd : sig[sel];
      v   = v ^ cfgb[`GDO_BIT_INV];
      return {(sel != `GDO_SEL_TRISTATE), v};
   endfunction : gdo_pick

   logic [2:0] pout_nxt, poe_nxt;
   always_comb begin
      {poe_nxt[2], pout_nxt[2]} = gdo_pick(pin2_output_config, PIN_SIGNALS, clkdiv_r);
      {poe_nxt[1], pout_nxt[1]} = gdo_pick(pin1_output_config, PIN_SIGNALS, clkdiv_r);
      {poe_nxt[0], pout_nxt[0]} = gdo_pick(pin0_output_config, PIN_SIGNALS, clkdiv_r);
   end

   //------------------------------------------------------------
   // wake test values, internal only
   //------------------------------------------------------------
   logic [7:0] ta_r, ta_nxt, tb_r, tb_nxt;
   always_comb begin
      ta_nxt = ta_r;
      tb_nxt = tb_r;
      if (WAKE) begin
         ta_nxt = fifo_threshold_config[`GDO_BIT_RET] ? `GDO_TESTA_RET1 : `GDO_TESTA_RET0;
         tb_nxt = fifo_threshold_config[`GDO_BIT_RET] ? `GDO_TESTB_RET1 : `GDO_TESTB_RET0;
      end
   end
   // no readback path: test bytes leave only as analog outputs

   //------------------------------------------------------------
   // fifo thresholds
   //------------------------------------------------------------
   function automatic logic [6:0] gdo_rx_thr(input logic [3:0] n);
      return {1'b0, n, 2'b00} + 7'h04;
   endfunction : gdo_rx_thr

   logic tx_hit_nxt, rx_hit_nxt;
   logic [6:0] rx_thr;
   always_comb begin
      rx_thr     = gdo_rx_thr(fifo_threshold_config[`GDO_LVL_HI:0]);
      rx_hit_nxt = (RX_COUNT >= rx_thr);
      tx_hit_nxt = (TX_COUNT >= (`GDO_TX_BASE - rx_thr));
   end

   //------------------------------------------------------------
   // level outputs taken from the register fields
   //------------------------------------------------------------
   logic       drive_nxt;   // shared drive strength
   logic       temp_nxt;    // temperature sensor enable
   logic [1:0] atten_nxt;   // close-in attenuation code
   // plain field copies; the register stage below keeps outputs glitch free
   always_comb begin
      drive_nxt = pin1_output_config[`GDO_BIT_TOP];
      temp_nxt  = pin0_output_config[`GDO_BIT_TOP];
      atten_nxt = fifo_threshold_config[`GDO_ATT_HI:`GDO_ATT_LO];
   end

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   // read answer: pulse and byte leave together so the host takes both at one edge
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rd_pend_r <= 1'b0;
         RDATA     <= 8'h00;
         RVALID    <= 1'b0;
      end else begin
         rd_pend_r <= rd_pend_nxt;
         RDATA     <= rdata_nxt;
         RVALID    <= rd_pend_r;
      end
   end

   // divider runs free, so the clock phase on a pin is not tied to any write
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         div_r    <= 8'h00;
         clkdiv_r <= 1'b0;
      end else begin
         div_r    <= div_nxt;
         clkdiv_r <= clkdiv_nxt;
      end
   end

   // pin drivers; registered so a select change cannot glitch a pin
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PIN_OUT <= 3'h0;   // pins stay released while in reset
         PIN_OE  <= 3'h0;
      end else begin
         PIN_OUT <= pout_nxt;
         PIN_OE  <= poe_nxt;
      end
   end

   // level outputs follow their fields one edge after a write
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         DRIVE_HIGH     <= 1'b0;
         TEMP_SENSOR_EN <= 1'b0;
         RX_ATTEN       <= 2'h0;
      end else begin
         DRIVE_HIGH     <= drive_nxt;
         TEMP_SENSOR_EN <= temp_nxt;
         RX_ATTEN       <= atten_nxt;
      end
   end

   // wake test values; reset gives the retention-off pair
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ta_r          <= `GDO_TESTA_RET0;
         tb_r          <= `GDO_TESTB_RET0;
         ANALOG_TEST_A <= `GDO_TESTA_RET0;
         ANALOG_TEST_B <= `GDO_TESTB_RET0;
      end else begin
         ta_r          <= ta_nxt;
         tb_r          <= tb_nxt;
         ANALOG_TEST_A <= ta_nxt;
         ANALOG_TEST_B <= tb_nxt;
      end
   end

   // threshold flags lag the counts by one edge
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         TX_THR_HIT <= 1'b0;
         RX_THR_HIT <= 1'b0;
      end else begin
         TX_THR_HIT <= tx_hit_nxt;
         RX_THR_HIT <= rx_hit_nxt;
      end
   end
endmodule : gdo_cfg_top

// >>> hw/gdo_map.svh
// Summary of operation
// - bit 6 inverts selected pin signal
// - pin2 select bits 5:0 reset 0x29
// - pin1 select resets 0x2E, tri-state
// - pin0 select resets 0x3F, clock/192
// - pin1 bit 7 sets shared drive
// - wake applies test values by retention
// - test changes internal only, reads reset
// - level setting bits 3:0 reset 7
// - one setting, both fifos thresholds
`ifndef GDO_MAP_SVH
`define GDO_MAP_SVH
//------------------------------------------------------------
// register offsets
//------------------------------------------------------------
`define GDO_OFS_PIN2      6'h00
`define GDO_OFS_PIN1      6'h01
`define GDO_OFS_PIN0      6'h02
`define GDO_OFS_FIFOTH    6'h03
//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define GDO_BIT_INV       6
`define GDO_BIT_RET       6
`define GDO_BIT_TOP       7
`define GDO_SEL_HI        5
`define GDO_ATT_HI        5
`define GDO_ATT_LO        4
`define GDO_LVL_HI        3
//------------------------------------------------------------
// reset values
//------------------------------------------------------------
`define GDO_RST_PIN2      8'h29
`define GDO_RST_PIN1      8'h2E
`define GDO_RST_PIN0      8'h3F
`define GDO_RST_FIFOTH    8'h07
`define GDO_SEL_TRISTATE  6'h2E
`define GDO_SEL_CLKDIV    6'h3F
`define GDO_SEL_CHIPRDY   6'h29
`define GDO_TESTA_RET0    8'h31
`define GDO_TESTA_RET1    8'h35
`define GDO_TESTB_RET0    8'h88
`define GDO_TESTB_RET1    8'h81
`define GDO_TX_BASE       7'h41
`define GDO_DIV_COUNT     192
`endif

// >>> hw/gdo_pkg.sv
package gdo_pkg;
   typedef logic [7:0] gdo_byte_t;   // one register byte
   typedef logic [6:0] gdo_count_t;  // fifo byte count 0..64
   typedef logic [5:0] gdo_addr_t;   // register address
endpackage : gdo_pkg

// >>> hw/gdo_reg_store.sv
`timescale 1ns/1ps
`include "gdo_map.svh"
// four retained registers; contents are independent of sleep
module gdo_reg_store (
   // clock and reset
   input  wire logic CLK,
   input  wire logic RST,
   // access port
   gdo_cfg_if.store  bus,
   // live contents
   output logic [31:0] regs_q
);
   import gdo_pkg::*;
   logic [31:0] regs_r, regs_nxt;   // packed registers, index 0 low
   logic [7:0]  rd_r, rd_nxt;       // read data register

   // next values: write merges one byte, read registered
   always_comb begin
      regs_nxt = regs_r;
      if (bus.we) begin
         regs_nxt[bus.idx*8 +: 8] = bus.wdata;
      end
      regs_nxt[`GDO_BIT_TOP] = 1'b0;
      rd_nxt = regs_nxt[bus.idx*8 +: 8];
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         regs_r <= {`GDO_RST_FIFOTH, `GDO_RST_PIN0, `GDO_RST_PIN1, `GDO_RST_PIN2};
         rd_r   <= 8'h00;
      end else begin
         regs_r <= regs_nxt;
         rd_r   <= rd_nxt;
      end
   end

   assign bus.rdata = rd_r;
   assign regs_q    = regs_r;
endmodule : gdo_reg_store

// >>> testbench/gdo_cfg_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks against a shadow of the bank
// ----------------------------------------
module gdo_cfg_checker (
   // clock, reset and access
   input wire logic               CLK, RST, WE, RE, RVALID, WAKE,
   input wire gdo_pkg::gdo_addr_t ADDR,
   input wire gdo_pkg::gdo_byte_t WDATA, RDATA, ANALOG_TEST_A,
   // fifo side and field outputs
   input wire gdo_pkg::gdo_count_t TX_COUNT, RX_COUNT,
   input wire logic [2:0]          PIN_OE,
   input wire logic [1:0]          RX_ATTEN,
   input wire logic                DRIVE_HIGH, TX_THR_HIT, RX_THR_HIT
);
   logic [7:0] sh_r [4];                                  // shadow of the four registers
   wire  [6:0] rx_thr = {sh_r[3][3:0], 2'b00} + 7'h04;    // receive threshold
   wire  [6:0] tx_thr = 7'h41 - rx_thr;                   // transmit threshold
   // shadow follows every mapped write
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) sh_r <= '{8'h29, 8'h2E, 8'h3F, 8'h07};
      else if (WE && ADDR < 6'h04) sh_r[ADDR[1:0]] <= WDATA;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_read;
      RE && ADDR < 6'h04;
   endsequence
   a_read_answer: assert property (s_read |-> ##2 RVALID)
      else $error("read not answered");
   a_unmapped_quiet: assert property (RE && ADDR > 6'h03 |-> ##2 !RVALID)
      else $error("unmapped read answered");
   a_rdata_idle: assert property (!RVALID |-> RDATA == 8'h00)
      else $error("read data outside pulse");
   a_rx_level: assert property (RX_THR_HIT == ($past(RX_COUNT) >= $past(rx_thr)))
      else $error("receive level wrong");
   a_tx_level: assert property (TX_THR_HIT == ($past(TX_COUNT) >= $past(tx_thr)))
      else $error("transmit level wrong");
   a_atten_follow: assert property (RX_ATTEN == $past(sh_r[3][5:4]))
      else $error("attenuation wrong");
   a_drive_follow: assert property (DRIVE_HIGH == $past(sh_r[1][7]))
      else $error("drive strength wrong");
   a_oe_tristate: assert property (PIN_OE[1] == ($past(sh_r[1][5:0]) != 6'h2E))
      else $error("pin1 enable wrong");
   a_wake_load: assert property (WAKE |=> ANALOG_TEST_A == ($past(sh_r[3][6]) ? 8'h35 : 8'h31))
      else $error("wake value wrong");
   a_test_hold: assert property (!WAKE |=> $stable(ANALOG_TEST_A))
      else $error("test value moved");
endmodule : gdo_cfg_checker
bind gdo_cfg_top gdo_cfg_checker u_chk (
   .CLK           (CLK),
   .RST           (RST),
   .WE            (WE),
   .RE            (RE),
   .RVALID        (RVALID),
   .WAKE          (WAKE),
   .ADDR          (ADDR),
   .WDATA         (WDATA),
   .RDATA         (RDATA),
   .ANALOG_TEST_A (ANALOG_TEST_A),
   .TX_COUNT      (TX_COUNT),
   .RX_COUNT      (RX_COUNT),
   .PIN_OE        (PIN_OE),
   .RX_ATTEN      (RX_ATTEN),
   .DRIVE_HIGH    (DRIVE_HIGH),
   .TX_THR_HIT    (TX_THR_HIT),
   .RX_THR_HIT    (RX_THR_HIT)
);

// >>> testbench/gdo_cfg_top_test.sv
`timescale 1ns/1ps
module gdo_cfg_top_test;
   import gdo_pkg::*;
   logic CLK, RST, WAKE, WE, RE, RVALID, DRIVE_HIGH, TEMP_SENSOR_EN, TX_THR_HIT, RX_THR_HIT, ok;
   logic [63:0] PIN_SIGNALS;
   logic [2:0]  PIN_OUT, PIN_OE;
   logic [1:0]  RX_ATTEN;
   gdo_count_t  TX_COUNT, RX_COUNT;
   gdo_addr_t   ADDR;
   gdo_byte_t   WDATA, RDATA, ANALOG_TEST_A, ANALOG_TEST_B, got;
   int          failures, samples_checked;
   gdo_cfg_top u_dut (
      .CLK            (CLK),
      .RST            (RST),
      .ADDR           (ADDR),
      .WE             (WE),
      .RE             (RE),
      .WDATA          (WDATA),
      .RDATA          (RDATA),
      .RVALID         (RVALID),
      .PIN_SIGNALS    (PIN_SIGNALS),
      .WAKE           (WAKE),
      .TX_COUNT       (TX_COUNT),
      .RX_COUNT       (RX_COUNT),
      .PIN_OUT        (PIN_OUT),
      .PIN_OE         (PIN_OE),
      .DRIVE_HIGH     (DRIVE_HIGH),
      .TEMP_SENSOR_EN (TEMP_SENSOR_EN),
      .ANALOG_TEST_A  (ANALOG_TEST_A),
      .ANALOG_TEST_B  (ANALOG_TEST_B),
      .RX_ATTEN       (RX_ATTEN),
      .TX_THR_HIT     (TX_THR_HIT),
      .RX_THR_HIT     (RX_THR_HIT)
   );
   gdo_host_model u_host (
      .CLK    (CLK),
      .RVALID (RVALID),
      .RDATA  (RDATA),
      .ADDR   (ADDR),
      .WE     (WE),
      .RE     (RE),
      .WDATA  (WDATA)
   );
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic end_sim;
      $display("compares %0d, wrong %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   // a hung run counts as a mismatch
   initial begin
      repeat (20000) @(posedge CLK);
      failures++;
      end_sim();
   end
   initial begin
      int n;
      int cyc;
      logic lvl;
      RST = 1'b1;
      WAKE = 1'b0;
      // bit 41 carries chip-ready, bit 5 a plain core signal
      PIN_SIGNALS = 64'h0000_0200_0000_0020;
      TX_COUNT = 7'h00;
      RX_COUNT = 7'h00;
      failures = 0;
      samples_checked = 0;
      repeat (4) @(negedge CLK);
      RST = 1'b0;
      u_host.rd(6'h00, got, ok); chk(got, 8'h29);
      u_host.rd(6'h01, got, ok); chk(got, 8'h2E);
      u_host.rd(6'h02, got, ok); chk(got, 8'h3F);
      u_host.rd(6'h03, got, ok); chk(got, 8'h07);
      chk({5'h00, PIN_OE}, 8'h05);
      chk({7'h00, PIN_OUT[2]}, 8'h01);
      // pin0 clock output: measure one half period of the square wave
      lvl = PIN_OUT[0];
      cyc = 0;
      while (PIN_OUT[0] === lvl && cyc < 200) begin
         @(negedge CLK);
         cyc++;
      end
      lvl = PIN_OUT[0];
      cyc = 0;
      while (PIN_OUT[0] === lvl && cyc < 200) begin
         @(negedge CLK);
         cyc++;
      end
      chk(8'(cyc), 8'h60);
      u_host.wr(6'h02, 8'h00);
      u_host.wr(6'h01, 8'hC5);
      u_host.wr(6'h00, 8'hC1);
      u_host.rd(6'h00, got, ok); chk(got, 8'h41);
      u_host.rd(6'h01, got, ok); chk(got, 8'hC5);
      chk({5'h00, PIN_OUT}, 8'h04);
      chk({7'h00, DRIVE_HIGH}, 8'h01);
      // each setting at its edges, attenuation riding along
      for (n = 0; n < 16; n++) begin
         u_host.wr(6'h03, {2'b00, 2'(n), 4'(n)});
         @(negedge CLK);
         RX_COUNT = 7'(4 * n + 4);
         TX_COUNT = 7'(60 - 4 * n);
         repeat (2) @(negedge CLK);
         chk({6'h00, TX_THR_HIT, RX_THR_HIT}, 8'h01);
         chk({6'h00, RX_ATTEN}, 8'(n % 4));
         RX_COUNT = 7'(4 * n + 3);
         TX_COUNT = 7'(61 - 4 * n);
         repeat (2) @(negedge CLK);
         chk({6'h00, TX_THR_HIT, RX_THR_HIT}, 8'h02);
      end
      // wake values follow the retention bit
      for (n = 1; n >= 0; n--) begin
         u_host.wr(6'h03, n ? 8'h47 : 8'h07);
         WAKE = 1'b1;
         @(negedge CLK);
         WAKE = 1'b0;
         @(negedge CLK);
         chk(ANALOG_TEST_A, n ? 8'h35 : 8'h31);
         chk(ANALOG_TEST_B, n ? 8'h81 : 8'h88);
         u_host.rd(6'h03, got, ok); chk(got, n ? 8'h47 : 8'h07);
      end
      u_host.wr(6'h02, 8'h80);
      @(negedge CLK);
      chk({7'h00, TEMP_SENSOR_EN}, 8'h01);
      u_host.rd(6'h05, got, ok); chk({7'h00, ok}, 8'h00);
      end_sim();
   end
endmodule : gdo_cfg_top_test

// >>> testbench/gdo_host_model.sv
`timescale 1ns/1ps
// host side of the register port; drives on falling edges
module gdo_host_model (
   input wire logic               CLK, RVALID,
   input wire gdo_pkg::gdo_byte_t RDATA,
   output gdo_pkg::gdo_addr_t     ADDR,
   output logic                   WE, RE,
   output gdo_pkg::gdo_byte_t     WDATA
);
   initial begin
      ADDR = 6'h00;
      WE = 1'b0;
      RE = 1'b0;
      WDATA = 8'h00;
   end
   // one write cycle
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = (a == 6'h02 && d[7]) ? 8'h80 : d;
      if (a == 6'h03) v[7] = 1'b0;
      @(negedge CLK);
      ADDR = a;
      WDATA = v;
      WE = 1'b1;
      @(negedge CLK);
      WE = 1'b0;
      WDATA = ~v; // released data must not look stale
   endtask : wr
   // one read; ok stays low when no answer comes
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(negedge CLK);
      ADDR = a;
      RE = 1'b1;
      @(negedge CLK);
      RE = 1'b0;
      // answer taken at the rising edge where the pulse is sampled high
      repeat (3) begin
         @(posedge CLK);
         if (RVALID === 1'b1) begin
            ok = 1'b1;
            d = RDATA;
         end
      end
      // hand back mid-cycle so later checks see settled outputs
      @(negedge CLK);
   endtask : rd
endmodule : gdo_host_model
